// [hw/rtcal_pkg.sv]
// Purpose: shared constants and types of the alarm and minute/second time block
// Assumes: 8-bit registers behind a plain strobe port, one clock domain
// Notes:   register offsets are word indices on a 4-bit address
package rtcal_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [3:0] ADDR_TIME_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_MINUTES    = 4'h1;
  localparam logic [3:0] ADDR_SECONDS    = 4'h2;
  localparam logic [3:0] ADDR_ALARM_CTRL = 4'h3;
  localparam logic [3:0] ADDR_ALARM_RPT  = 4'h4;
  localparam logic [3:0] ADDR_ALARM_MTH  = 4'h5;
  localparam logic [3:0] ADDR_ALARM_WDAY = 4'h6;
  localparam logic [3:0] ADDR_ALARM_DAY  = 4'h7;
  localparam logic [3:0] ADDR_ALARM_HOUR = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h9;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'ha;

  // implemented-bit masks; other bits store nothing and read zero
  localparam logic [7:0] TIME_CTRL_BITS  = 8'h28;
  localparam logic [7:0] MINSEC_BITS     = 8'h7f;
  localparam logic [7:0] ALARM_CTRL_BITS = 8'hfc;
  localparam logic [7:0] MONTH_BITS      = 8'h1f;
  localparam logic [7:0] WDAY_BITS       = 8'h07;
  localparam logic [7:0] DAY_HOUR_BITS   = 8'h3f;
  localparam logic [7:0] IRQ_BITS        = 8'h07;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;

  // field positions
  localparam int unsigned UNLOCK_BIT   = 5;
  localparam int unsigned HALF_BIT     = 3;
  localparam int unsigned ALARM_EN_BIT = 7;
  localparam int unsigned CHIME_BIT    = 6;
  localparam int unsigned ALARM_INTERVAL_MASK_MSB    = 5;
  localparam int unsigned ALARM_INTERVAL_MASK_LSB    = 2;
  localparam int unsigned IRQ_ALARM    = 0;
  localparam int unsigned IRQ_SECOND   = 1;
  localparam int unsigned IRQ_MINUTE   = 2;
  localparam int unsigned IRQ_W        = 3;

  // alarm interval codes
  localparam logic [3:0] AM_HALF_SEC = 4'h0;
  localparam logic [3:0] AM_SECOND   = 4'h1;
  localparam logic [3:0] AM_TEN_SEC  = 4'h2;
  localparam logic [3:0] AM_MINUTE   = 4'h3;
  localparam logic [3:0] AM_TEN_MIN  = 4'h4;
  localparam logic [3:0] AM_HOUR     = 4'h5;
  localparam logic [3:0] AM_DAY      = 4'h6;
  localparam logic [3:0] AM_WEEK     = 4'h7;
  localparam logic [3:0] AM_MONTH    = 4'h8;
  localparam logic [3:0] AM_YEAR     = 4'h9;

  // bcd limits and repeat counter ends
  localparam logic [3:0] BCD_UNITS_MAX = 4'h9;
  localparam logic [2:0] BCD_TENS_MAX  = 3'h5;
  localparam logic [7:0] RPT_ZERO      = 8'h00;
  localparam logic [7:0] RPT_FULL      = 8'hff;

  // current calendar supplied by the neighbouring calendar block
  typedef struct packed {
    logic [7:0] month;
    logic [7:0] weekday;
    logic [7:0] day;
    logic [7:0] hour;
  } rtcal_date_t;

  // alarm minute and second compare values, held elsewhere
  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtcal_alarm_ms_t;

endpackage

// [hw/rtcal_bcd60.sv]
// Purpose: two-digit bcd counter from 00 to 59 with load and wrap
// Assumes: step is a one-cycle pulse
// Notes:   an out-of-range units digit rolls over on the next step, a tens digit on the step that wraps the units
`timescale 1ns/10ps
module rtcal_bcd60 (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [6:0] load_value,
  input  wire logic       step,
  output logic      [6:0] value,
  output logic            wrap
);

  logic units_top;
  logic tens_top;

  // >= so a bad bcd value written by software still recovers
  assign units_top = value[3:0] >= rtcal_pkg::BCD_UNITS_MAX;
  assign tens_top  = value[6:4] >= rtcal_pkg::BCD_TENS_MAX;
  assign wrap      = step && units_top && tens_top;

  // units then tens, load wins over a step
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      value <= 7'h00;
    end
    else if (load)
    begin
      value <= load_value;
    end
    else if (step)
    begin
      if (units_top)
      begin
        value[3:0] <= 4'h0;
        value[6:4] <= tens_top ? 3'h0 : value[6:4] + 3'h1;
      end
      else
      begin
        value[3:0] <= value[3:0] + 4'h1;
      end
    end
  end

endmodule

// [hw/rtcal_alarm_time.sv]
// Purpose: minute/second time keeping with write lock and the calendar alarm
// Assumes: half_tick is a one-cycle pulse every half second from the time base
// Notes:   hours and above live in a neighbouring block fed by minute_carry
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps

// What this block does
// - minutes register holds bcd tens and units
// - seconds register holds bcd tens and units
// - time writes accepted only while unlocked
// - alarm enable self-clears at count zero, no chime
// - chime wraps repeat count from 00 to ff
// - without chime repeat count stays at 00
// - mask codes 0 to 5 pick short intervals
// - codes 6 to 9 daily to yearly
// - repeat count decrements on each alarm event
// - repeat value counts further repeats, resets zero
// - alarm month register bcd, upper bits zero
// - alarm weekday register 0 to 7
// - alarm day register bcd, upper bits zero
// - alarm hour register bcd, upper bits zero
// - cleared unlock bit locks time registers
module rtcal_alarm_time (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic [rtcal_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [rtcal_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [rtcal_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                          half_tick,
  input  wire rtcal_pkg::rtcal_date_t        cur_date,
  input  wire rtcal_pkg::rtcal_alarm_ms_t    alarm_ms,
  output logic                               alarm_pulse,
  output logic                               minute_carry,
  output logic                               irq
);

  // register address decode shared by the strobes and the read path
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  logic [7:0] time_ctrl;
  logic       half_phase;
  logic [7:0] alarm_ctrl;
  logic [7:0] alarm_rpt;
  logic [7:0] alarm_month;
  logic [7:0] alarm_wday;
  logic [7:0] alarm_day;
  logic [7:0] alarm_hour;
  logic [rtcal_pkg::IRQ_W-1:0] irq_status;
  logic [rtcal_pkg::IRQ_W-1:0] irq_mask;
  logic [rtcal_pkg::IRQ_W-1:0] irq_events;

  logic       unlocked;
  logic       wr_minutes;
  logic       wr_seconds;
  logic       second_step;
  logic [6:0] minutes_value;
  logic [6:0] seconds_value;
  logic       sec_wrap;
  logic       min_wrap;

  logic       eval_half;
  logic       eval_second;
  logic [3:0] alarm_interval_mask;
  logic       alarm_on;
  logic       chime_on;
  logic       code_legal;
  logic       fields_match;
  logic       alarm_match;
  logic       alarm_fire;
  logic [7:0] next_rdata;

  // lock gate for the time value registers
  assign unlocked   = time_ctrl[rtcal_pkg::UNLOCK_BIT];
  assign wr_minutes = reg_wr && hit(reg_addr, rtcal_pkg::ADDR_MINUTES) && unlocked;
  assign wr_seconds = reg_wr && hit(reg_addr, rtcal_pkg::ADDR_SECONDS) && unlocked;

  // a second passes on the tick that ends the second half
  assign second_step = half_tick && half_phase && !wr_seconds;

  // time control: only the unlock bit is writable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      time_ctrl <= rtcal_pkg::ZERO_BYTE;
    end
    else if (reg_wr && hit(reg_addr, rtcal_pkg::ADDR_TIME_CTRL))
    begin
      time_ctrl <= reg_wdata & (rtcal_pkg::TIME_CTRL_BITS & ~(8'h01 << rtcal_pkg::HALF_BIT));
    end
  end

  // half-second phase; a seconds write restarts the second
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      half_phase <= 1'b0;
    end
    else if (wr_seconds)
    begin
      half_phase <= 1'b0;
    end
    else if (half_tick)
    begin
      half_phase <= !half_phase;
    end
  end

  // seconds digits, write masked to the bcd fields
  rtcal_bcd60 u_seconds (
    .core_clk   (core_clk),
    .rst        (rst),
    .load       (wr_seconds),
    .load_value (reg_wdata[6:0]),
    .step       (second_step),
    .value      (seconds_value),
    .wrap       (sec_wrap)
  );

  // minutes digits advance on the seconds wrap
  rtcal_bcd60 u_minutes (
    .core_clk   (core_clk),
    .rst        (rst),
    .load       (wr_minutes),
    .load_value (reg_wdata[6:0]),
    .step       (sec_wrap),
    .value      (minutes_value),
    .wrap       (min_wrap)
  );

  // carry towards the hour counter, registered to keep it glitch free
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      minute_carry <= 1'b0;
    end
    else
    begin
      minute_carry <= min_wrap && !wr_minutes;
    end
  end

  // compare one cycle after the tick, once the seconds have settled
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      eval_half   <= 1'b0;
      eval_second <= 1'b0;
    end
    else
    begin
      eval_half   <= half_tick;
      eval_second <= second_step;
    end
  end

  assign alarm_interval_mask    = alarm_ctrl[rtcal_pkg::ALARM_INTERVAL_MASK_MSB:rtcal_pkg::ALARM_INTERVAL_MASK_LSB];
  assign alarm_on = alarm_ctrl[rtcal_pkg::ALARM_EN_BIT];
  assign chime_on = alarm_ctrl[rtcal_pkg::CHIME_BIT];

  // reserved codes never match; software is expected not to use them
  assign code_legal = (alarm_interval_mask <= rtcal_pkg::AM_YEAR);

  // each longer interval adds the next field to the compare; month compares the day in place of the weekday
  always_comb
  begin
    fields_match = 1'b1;
    if (alarm_interval_mask >= rtcal_pkg::AM_TEN_SEC)
      fields_match = fields_match && (seconds_value[3:0] == alarm_ms.seconds[3:0]);
    if (alarm_interval_mask >= rtcal_pkg::AM_MINUTE)
      fields_match = fields_match && (seconds_value[6:4] == alarm_ms.seconds[6:4]);
    if (alarm_interval_mask >= rtcal_pkg::AM_TEN_MIN)
      fields_match = fields_match && (minutes_value[3:0] == alarm_ms.minutes[3:0]);
    if (alarm_interval_mask >= rtcal_pkg::AM_HOUR)
      fields_match = fields_match && (minutes_value[6:4] == alarm_ms.minutes[6:4]);
    if (alarm_interval_mask >= rtcal_pkg::AM_DAY)
      fields_match = fields_match && ((cur_date.hour & rtcal_pkg::DAY_HOUR_BITS) == alarm_hour);
    if (alarm_interval_mask == rtcal_pkg::AM_WEEK)
      fields_match = fields_match && ((cur_date.weekday & rtcal_pkg::WDAY_BITS) == alarm_wday);
    if (alarm_interval_mask >= rtcal_pkg::AM_MONTH)
      fields_match = fields_match && ((cur_date.day & rtcal_pkg::DAY_HOUR_BITS) == alarm_day);
    // feb 29 only exists in leap years, so a yearly compare set to feb 29 fires every four years
    if (alarm_interval_mask == rtcal_pkg::AM_YEAR)
      fields_match = fields_match && ((cur_date.month & rtcal_pkg::MONTH_BITS) == alarm_month);
  end

  // half-second code fires on every tick, the rest on second boundaries
  assign alarm_match = (alarm_interval_mask == rtcal_pkg::AM_HALF_SEC) ? eval_half
                                                         : (eval_second && code_legal && fields_match);
  assign alarm_fire  = alarm_on && alarm_match;

  // alarm event strobe out of a flop
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_pulse <= 1'b0;
    end
    else
    begin
      alarm_pulse <= alarm_fire;
    end
  end

  // alarm control; a write in the event cycle wins over the self clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_ctrl <= rtcal_pkg::ZERO_BYTE;
    end
    else if (reg_wr && hit(reg_addr, rtcal_pkg::ADDR_ALARM_CTRL))
    begin
      alarm_ctrl <= reg_wdata & rtcal_pkg::ALARM_CTRL_BITS;
    end
    else if (alarm_fire && (alarm_rpt == rtcal_pkg::RPT_ZERO) && !chime_on)
    begin
      alarm_ctrl[rtcal_pkg::ALARM_EN_BIT] <= 1'b0;
    end
  end

  // repeat counter: counts down, wraps only with chime
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_rpt <= rtcal_pkg::RPT_ZERO;
    end
    else if (reg_wr && hit(reg_addr, rtcal_pkg::ADDR_ALARM_RPT))
    begin
      alarm_rpt <= reg_wdata;
    end
    else if (alarm_fire)
    begin
      if (alarm_rpt != rtcal_pkg::RPT_ZERO)
        alarm_rpt <= alarm_rpt - 8'h01;
      else if (chime_on)
        alarm_rpt <= rtcal_pkg::RPT_FULL;
      else
        alarm_rpt <= rtcal_pkg::RPT_ZERO;
    end
  end

  // alarm date compare registers, unimplemented bits dropped on write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_month <= rtcal_pkg::ZERO_BYTE;
      alarm_wday  <= rtcal_pkg::ZERO_BYTE;
      alarm_day   <= rtcal_pkg::ZERO_BYTE;
      alarm_hour  <= rtcal_pkg::ZERO_BYTE;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_MTH))
        alarm_month <= reg_wdata & rtcal_pkg::MONTH_BITS;
      if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_WDAY))
        alarm_wday <= reg_wdata & rtcal_pkg::WDAY_BITS;
      if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_DAY))
        alarm_day <= reg_wdata & rtcal_pkg::DAY_HOUR_BITS;
      if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_HOUR))
        alarm_hour <= reg_wdata & rtcal_pkg::DAY_HOUR_BITS;
    end
  end

  // interrupt sources: alarm, second and minute
  assign irq_events = {minute_carry, eval_second, alarm_pulse};

  // sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_status <= '0;
    end
    else if (reg_wr && hit(reg_addr, rtcal_pkg::ADDR_IRQ_STATUS))
    begin
      irq_status <= (irq_status & ~reg_wdata[rtcal_pkg::IRQ_W-1:0]) | irq_events;
    end
    else
    begin
      irq_status <= irq_status | irq_events;
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_mask <= '0;
    end
    else if (reg_wr && hit(reg_addr, rtcal_pkg::ADDR_IRQ_MASK))
    begin
      irq_mask <= reg_wdata[rtcal_pkg::IRQ_W-1:0];
    end
  end

  // level interrupt while any enabled flag is set
  assign irq = |(irq_status & irq_mask);

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = rtcal_pkg::ZERO_BYTE;
    if (hit(reg_addr, rtcal_pkg::ADDR_TIME_CTRL))
    begin
      next_rdata = time_ctrl;
      next_rdata[rtcal_pkg::HALF_BIT] = half_phase;
    end
    if (hit(reg_addr, rtcal_pkg::ADDR_MINUTES))
      next_rdata = {1'b0, minutes_value};
    if (hit(reg_addr, rtcal_pkg::ADDR_SECONDS))
      next_rdata = {1'b0, seconds_value};
    if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_CTRL))
      next_rdata = alarm_ctrl;
    if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_RPT))
      next_rdata = alarm_rpt;
    if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_MTH))
      next_rdata = alarm_month;
    if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_WDAY))
      next_rdata = alarm_wday;
    if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_DAY))
      next_rdata = alarm_day;
    if (hit(reg_addr, rtcal_pkg::ADDR_ALARM_HOUR))
      next_rdata = alarm_hour;
    if (hit(reg_addr, rtcal_pkg::ADDR_IRQ_STATUS))
      next_rdata = {5'h00, irq_status};
    if (hit(reg_addr, rtcal_pkg::ADDR_IRQ_MASK))
      next_rdata = {5'h00, irq_mask};
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= rtcal_pkg::ZERO_BYTE;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : rtcal_pkg::ZERO_BYTE;
    end
  end

endmodule

// [verif/rtcal_alarm_time_properties.sv]
// Purpose: port-level checks of the alarm and minute/second time block
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module rtcal_alarm_time_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       half_tick,
  input wire logic       alarm_pulse,
  input wire logic       minute_carry,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // read port answers only in the cycle after a read strobe
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 4'hf |=> reg_rdata == 8'h00)
    else $error("unmapped index read nonzero");
  // unimplemented bits of the minutes, seconds, alarm control and alarm date registers read zero
  minute_top_a: assert property (reg_rd && reg_addr == rtcal_pkg::ADDR_MINUTES |=> !reg_rdata[7])
    else $error("minutes bit 7 set");
  second_top_a: assert property (reg_rd && reg_addr == rtcal_pkg::ADDR_SECONDS |=> !reg_rdata[7])
    else $error("seconds bit 7 set");
  ctrl_low_a: assert property (reg_rd && reg_addr == rtcal_pkg::ADDR_ALARM_CTRL |=> reg_rdata[1:0] == 2'h0)
    else $error("alarm control bits 1-0 set");
  month_top_a: assert property (reg_rd && reg_addr == rtcal_pkg::ADDR_ALARM_MTH |=> reg_rdata[7:5] == 3'h0)
    else $error("alarm month upper bits set");
  wday_top_a: assert property (reg_rd && reg_addr == rtcal_pkg::ADDR_ALARM_WDAY |=> reg_rdata[7:3] == 5'h00)
    else $error("alarm weekday upper bits set");
  day_hour_top_a: assert property (reg_rd && (reg_addr == rtcal_pkg::ADDR_ALARM_DAY ||
    reg_addr == rtcal_pkg::ADDR_ALARM_HOUR) |=> reg_rdata[7:6] == 2'h0)
    else $error("alarm day or hour upper bits set");
  // an alarm event is a single pulse caused by a recent half tick
  pulse_single_a: assert property (alarm_pulse |=> !alarm_pulse)
    else $error("alarm pulse longer than one cycle");
  pulse_cause_a: assert property (alarm_pulse |-> $past(half_tick, 2) || $past(half_tick, 3))
    else $error("alarm pulse without a half tick");
  carry_cause_a: assert property (minute_carry |-> $past(half_tick) || $past(half_tick, 2))
    else $error("minute carry without a half tick");
  irq_masked_a: assert property (reg_wr && reg_addr == rtcal_pkg::ADDR_IRQ_MASK && reg_wdata == 8'h00 |=> !irq)
    else $error("interrupt high with all sources masked");

  cover property (alarm_pulse);
  cover property (minute_carry);
  cover property ($rose(irq));
endmodule

bind rtcal_alarm_time rtcal_alarm_time_chk chk (
  .core_clk     (core_clk),
  .rst          (rst),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .half_tick    (half_tick),
  .alarm_pulse  (alarm_pulse),
  .minute_carry (minute_carry),
  .irq          (irq)
);

// [verif/rtcal_alarm_time_test.sv]
// Purpose: register-level test of the alarm and minute/second time block
// Assumes: calendar and alarm minute/second inputs held at fixed values
// Notes:   calendar values equal the masked 0xff writes so every interval matches
`timescale 1ns/10ps
module rtcal_alarm_time_test;
  logic                         core_clk  = 1'b0;
  logic                         rst       = 1'b1;
  logic [3:0]                   reg_addr  = 4'h0;
  logic [7:0]                   reg_wdata = 8'h00;
  logic                         reg_wr    = 1'b0;
  logic                         reg_rd    = 1'b0;
  logic                         half_tick = 1'b0;
  logic [7:0]                   reg_rdata;
  logic                         alarm_pulse;
  logic                         minute_carry;
  logic                         irq;
  rtcal_pkg::rtcal_date_t       cur_date  = {8'h1f, 8'h07, 8'h3f, 8'h3f};
  rtcal_pkg::rtcal_alarm_ms_t   alarm_ms  = {8'h00, 8'h11};
  int                           num_errors = 0;
  int                           n_compared = 0;
  int                           pulses;
  int                           carries;
  logic [3:0]                   addrs [6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [7:0]                   wvals [6] = '{8'hdb, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0]                   masks [6] = '{8'hd8, 8'hff, 8'h1f, 8'h07, 8'h3f, 8'h3f};
  logic [7:0]                   rpt_exp [3] = '{8'h01, 8'h00, 8'h00};
  logic [7:0]                   code_exp [11] = '{8'h04, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01,
                                                  8'h01, 8'h01, 8'h01, 8'h01, 8'h00};

  rtcal_alarm_time uut (
    .core_clk     (core_clk),
    .rst          (rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .half_tick    (half_tick),
    .cur_date     (cur_date),
    .alarm_ms     (alarm_ms),
    .alarm_pulse  (alarm_pulse),
    .minute_carry (minute_carry),
    .irq          (irq)
  );

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobes; a gap cycle keeps a strobe from being driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic irq_is(input logic exp);
    @(posedge core_clk);
    #1;
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  // half ticks spaced well apart; the window opens on the tick's own edge,
  // since the minute carry stands only in the cycle after that edge
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      half_tick <= 1'b1;
      @(posedge core_clk);
      half_tick <= 1'b0;
      repeat (4)
      begin
        #1;
        pulses  += int'(alarm_pulse === 1'b1);
        carries += int'(minute_carry === 1'b1);
        @(posedge core_clk);
      end
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    pulses  = 0;
    carries = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(rtcal_pkg::ADDR_ALARM_CTRL, 8'h00);
    rd(rtcal_pkg::ADDR_ALARM_RPT, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(addrs[i], wvals[i]);
      rd(addrs[i], masks[i]);
    end
    wr(rtcal_pkg::ADDR_TIME_CTRL, 8'h00);
    wr(rtcal_pkg::ADDR_MINUTES, 8'h45);
    rd(rtcal_pkg::ADDR_MINUTES, 8'h00);
    wr(rtcal_pkg::ADDR_TIME_CTRL, 8'h20);
    wr(rtcal_pkg::ADDR_MINUTES, 8'hd9);
    rd(rtcal_pkg::ADDR_MINUTES, 8'h59);
    wr(rtcal_pkg::ADDR_SECONDS, 8'hb7);
    rd(rtcal_pkg::ADDR_SECONDS, 8'h37);
    rd(rtcal_pkg::ADDR_TIME_CTRL, 8'h20);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    // 59:59 rolls to 00:00 with one carry
    wr(rtcal_pkg::ADDR_SECONDS, 8'h59);
    tick(2);
    chk(8'(carries), 8'h01);
    rd(rtcal_pkg::ADDR_MINUTES, 8'h00);
    // counted alarm without chime: 2, 1, 0, then self-disable
    wr(rtcal_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(rtcal_pkg::ADDR_IRQ_STATUS, 8'h07);
    wr(rtcal_pkg::ADDR_ALARM_RPT, 8'h02);
    wr(rtcal_pkg::ADDR_ALARM_CTRL, 8'h80);
    for (int i = 0; i < 3; i++)
    begin
      pulses = 0;
      tick(1);
      chk(8'(pulses), 8'h01);
      rd(rtcal_pkg::ADDR_ALARM_RPT, rpt_exp[i]);
    end
    rd(rtcal_pkg::ADDR_ALARM_CTRL, 8'h00);
    irq_is(1'b1);
    wr(rtcal_pkg::ADDR_IRQ_STATUS, 8'h01);
    irq_is(1'b0);
    pulses = 0;
    tick(1);
    chk(8'(pulses), 8'h00);
    // chime wraps the count and keeps the alarm armed; masked source stays quiet
    wr(rtcal_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(rtcal_pkg::ADDR_ALARM_CTRL, 8'hc0);
    tick(1);
    rd(rtcal_pkg::ADDR_ALARM_RPT, 8'hff);
    rd(rtcal_pkg::ADDR_ALARM_CTRL, 8'hc0);
    irq_is(1'b0);
    wr(rtcal_pkg::ADDR_IRQ_MASK, 8'h01);
    irq_is(1'b1);
    // every interval code over two seconds, then the alarm switched off;
    // reserved codes are never written
    for (int c = 0; c < 11; c++)
    begin
      wr(rtcal_pkg::ADDR_SECONDS, 8'h10);
      wr(rtcal_pkg::ADDR_ALARM_CTRL, (c < 10) ? (8'hc0 | 8'(c << 2)) : 8'h44);
      pulses = 0;
      tick(4);
      chk(8'(pulses), code_exp[c]);
    end
    wrap_up();
  end
endmodule
